// ==== design/clock_select_pll_ctl.sv ====
// clock source select, fast rc postscaler, pll dividers, fail monitor
//
// Contract
// - twelve clock modes from the configuration fields
// - source picked at power-on from source and primary mode fields
// - unprogrammed configuration starts from the fast internal rc
// - selected clock halved into instruction and peripheral clocks
// - low-power rc feeds watchdog and clock fail monitor references
// - fast rc divided by a 3-bit postscale, one half to 1/256
// - pll input divided by 2 to 33 from a 5-bit field
// - pll oscillator core multiplied by 9-bit feedback field factor
// - prescale 0 gives 2, feedback 0x1E gives 32, postscale 0 gives 2
// - oscillator core output divided by 2, 4 or 8 via 2-bit field
// - pll clock is input times feedback over prescale times postscale
// - external clock mode takes the single input pin, no crystal drive
// - fail monitor finds a lost system clock and falls back
//
// The register addresses and strobed register access were decided locally.
`include "clk_ctl_defs.svh"

module clock_select_pll_ctl
  import clk_ctl_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`CCS_ADDR_W-1:0] regAddr,
  input wire logic [`CCS_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [`CCS_DATA_W-1:0] regRdData,
  input wire logic [2:0] initialSourceSelect,
  input wire logic [1:0] primaryOscMode,
  input wire logic configProgrammed,
  input wire logic fastRcClk,
  input wire logic primaryClk,
  input wire logic secondaryClk,
  input wire logic lowPowerRcClk,
  input wire logic pllOscClk,
  output logic pllRefTick,
  output logic pllFeedbackTick,
  output logic pllEnable,
  output logic instrClk,
  output logic periphClk,
  output logic watchdogRefClk,
  output logic monitorRefClk,
  output logic clockFailed,
  output logic crystalDriveEn,
  output logic secondaryOscEn,
  output logic [3:0] clockMode
);

  typedef struct packed {
    src_t srcSel;
    pmode_t primMode;
    logic captured;
    logic prevFrc;
    logic prevPri;
    logic prevSec;
    logic prevLprc;
    logic prevVco;
    logic lprcRef;
    logic fcyClk;
    logic [`CCS_DATA_W-1:0] clkDivReg;
    logic [8:0] pllFbReg;
    logic failFlag;
    logic [1:0] lprcNoTick;
    logic [`CCS_DATA_W-1:0] rdData;
  } ctl_state_t;

  ctl_state_t s_r;
  ctl_state_t s_nxt;

  initial begin
    if (DIV_W < 10) $error("clock_select_pll_ctl: DIV_W below 10");
  end

  // ---------------------------------------------------------------
  // source edges and field decode
  // ---------------------------------------------------------------
  logic frcEdge;
  logic priEdge;
  logic secEdge;
  logic lprcEdge;
  logic vcoEdge;
  logic foscTick;
  logic [2:0] rcSel;
  logic [1:0] postSel;
  logic [4:0] preSel;
  logic [DIV_W-1:0] rcFactor;
  logic [DIV_W-1:0] n1Factor;
  logic [DIV_W-1:0] mFactor;
  logic [DIV_W-1:0] n2Factor;
  logic isPllMode;
  logic [3:0] modeIdx;

  assign frcEdge = fastRcClk & ~s_r.prevFrc;
  assign priEdge = primaryClk & ~s_r.prevPri;
  assign secEdge = secondaryClk & ~s_r.prevSec;
  assign lprcEdge = lowPowerRcClk & ~s_r.prevLprc;
  assign vcoEdge = pllOscClk & ~s_r.prevVco;

  assign rcSel = s_r.clkDivReg[`CCS_RCDIV_LSB +: 3];
  assign postSel = s_r.clkDivReg[`CCS_POST_LSB +: 2];
  assign preSel = s_r.clkDivReg[`CCS_PRE_LSB +: 5];
  assign isPllMode = (s_r.srcSel == SRC_FRCPLL) ||
                     (s_r.srcSel == SRC_PRIPLL);

  always_comb begin
    rcFactor = DIV_W'(2) << rcSel;
    n1Factor = DIV_W'(preSel) + `CCS_PRE_OFFSET;
    mFactor = DIV_W'(s_r.pllFbReg) + `CCS_FB_OFFSET;
    case (postSel)
      2'b00: n2Factor = DIV_W'(2);
      2'b01: n2Factor = DIV_W'(4);
      2'b11: n2Factor = DIV_W'(8);
      default: n2Factor = DIV_W'(4);
    endcase
  end

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  div_if #(.W(DIV_W)) rcIf ();
  div_if #(.W(DIV_W)) preIf ();
  div_if #(.W(DIV_W)) fbIf ();
  div_if #(.W(DIV_W)) postIf ();

  assign rcIf.tickIn = frcEdge;
  assign rcIf.divisor = (s_r.srcSel == SRC_FRCDIV16) ?
                        DIV_W'(`CCS_FRC_DIV16) : rcFactor;
  // pll input is the fast rc or the primary oscillator
  assign preIf.tickIn = isPllMode &
                        ((s_r.srcSel == SRC_FRCPLL) ? frcEdge : priEdge);
  assign preIf.divisor = n1Factor;
  assign fbIf.tickIn = isPllMode & vcoEdge;
  assign fbIf.divisor = mFactor;
  assign postIf.tickIn = isPllMode & vcoEdge;
  assign postIf.divisor = n2Factor;

  tick_divider #(.W(DIV_W)) rcDiv (
    .clk(clk),
    .reset_n(reset_n),
    .dv(rcIf.div)
  );

  tick_divider #(.W(DIV_W)) preDiv (
    .clk(clk),
    .reset_n(reset_n),
    .dv(preIf.div)
  );

  tick_divider #(.W(DIV_W)) fbDiv (
    .clk(clk),
    .reset_n(reset_n),
    .dv(fbIf.div)
  );

  tick_divider #(.W(DIV_W)) postDiv (
    .clk(clk),
    .reset_n(reset_n),
    .dv(postIf.div)
  );

  // ---------------------------------------------------------------
  // system clock source mux
  // ---------------------------------------------------------------
  always_comb begin
    case (s_r.srcSel)
      SRC_FRC: foscTick = frcEdge;
      SRC_FRCPLL: foscTick = postIf.tickOut;
      // primary taken from one input pin
      SRC_PRI: foscTick = priEdge;
      SRC_PRIPLL: foscTick = postIf.tickOut;
      SRC_SEC: foscTick = secEdge;
      SRC_LOW_POWER_INTERNAL_RC: foscTick = lprcEdge;
      SRC_FRCDIV16: foscTick = rcIf.tickOut;
      SRC_FRCDIVN: foscTick = rcIf.tickOut;
      default: foscTick = frcEdge;
    endcase
  end

  always_comb begin
    case (s_r.srcSel)
      SRC_FRCDIVN: modeIdx = 4'h0;
      SRC_FRCDIV16: modeIdx = 4'h1;
      SRC_LOW_POWER_INTERNAL_RC: modeIdx = 4'h2;
      SRC_SEC: modeIdx = 4'h3;
      SRC_PRIPLL: modeIdx = (s_r.primMode == PM_HS) ? 4'h4 :
                            (s_r.primMode == PM_XT) ? 4'h5 : 4'h6;
      SRC_PRI: modeIdx = (s_r.primMode == PM_HS) ? 4'h7 :
                         (s_r.primMode == PM_XT) ? 4'h8 : 4'h9;
      SRC_FRCPLL: modeIdx = 4'hA;
      SRC_FRC: modeIdx = 4'hB;
      default: modeIdx = 4'hB;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic failClear;
  assign failClear = regWrite && (regAddr == `CCS_ADDR_STATUS) &&
                     regWrData[`CCS_FAIL_BIT];

  always_comb begin
    s_nxt = s_r;
    s_nxt.prevFrc = fastRcClk;
    s_nxt.prevPri = primaryClk;
    s_nxt.prevSec = secondaryClk;
    s_nxt.prevLprc = lowPowerRcClk;
    s_nxt.prevVco = pllOscClk;
    s_nxt.lprcRef = lowPowerRcClk;

    // power-on source capture, once after reset release
    if (!s_r.captured) begin
      s_nxt.captured = 1'b1;
      if (configProgrammed) begin
        s_nxt.srcSel = src_t'(initialSourceSelect);
        s_nxt.primMode = pmode_t'(primaryOscMode);
      end else begin
        s_nxt.srcSel = SRC_FRCDIVN;
        s_nxt.primMode = PM_OFF;
      end
    end

    if (foscTick) begin
      s_nxt.fcyClk = ~s_r.fcyClk;
    end

    // count reference edges without a system tick
    if (foscTick) begin
      s_nxt.lprcNoTick = 2'h0;
    end else if (lprcEdge && s_r.captured && !s_r.failFlag) begin
      if (s_r.lprcNoTick + 2'h1 >= `CCS_FAIL_LOW_POWER_INTERNAL_RC_EDGES) begin
        s_nxt.failFlag = 1'b1;
        s_nxt.srcSel = SRC_FRC;
        s_nxt.lprcNoTick = 2'h0;
      end else begin
        s_nxt.lprcNoTick = s_r.lprcNoTick + 2'h1;
      end
    end
    // clear by writing one; a new failure in that cycle wins
    if (failClear && !(s_nxt.failFlag && !s_r.failFlag)) begin
      s_nxt.failFlag = 1'b0;
    end

    if (regWrite) begin
      case (regAddr)
        `CCS_ADDR_CLOCK_DIVISOR_REG: s_nxt.clkDivReg = regWrData;
        `CCS_ADDR_PLL_FEEDBACK_REG: s_nxt.pllFbReg = regWrData[8:0];
        default: ;
      endcase
    end

    s_nxt.rdData = '0;
    if (regRead) begin
      case (regAddr)
        `CCS_ADDR_CLOCK_DIVISOR_REG: s_nxt.rdData = s_r.clkDivReg;
        `CCS_ADDR_PLL_FEEDBACK_REG: s_nxt.rdData = {7'h00, s_r.pllFbReg};
        `CCS_ADDR_STATUS: begin
          s_nxt.rdData[2:0] = s_r.srcSel;
          s_nxt.rdData[`CCS_FAIL_BIT] = s_r.failFlag;
          s_nxt.rdData[`CCS_MODE_LSB +: 4] = modeIdx;
          s_nxt.rdData[`CCS_PROG_BIT] = configProgrammed;
        end
        default: s_nxt.rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '{srcSel: SRC_FRCDIVN, primMode: PM_OFF, captured: 1'b0,
               prevFrc: 1'b0, prevPri: 1'b0, prevSec: 1'b0,
               prevLprc: 1'b0, prevVco: 1'b0, lprcRef: 1'b0,
               fcyClk: 1'b0, clkDivReg: `CCS_CLOCK_DIVISOR_REG_RST,
               pllFbReg: `CCS_PLL_FEEDBACK_REG_RST, failFlag: 1'b0,
               lprcNoTick: 2'h0, rdData: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign regRdData = s_r.rdData;
  assign pllRefTick = preIf.tickOut;
  assign pllFeedbackTick = fbIf.tickOut;
  assign pllEnable = isPllMode;
  assign instrClk = s_r.fcyClk;
  assign periphClk = s_r.fcyClk;
  assign watchdogRefClk = s_r.lprcRef;
  assign monitorRefClk = s_r.lprcRef;
  assign clockFailed = s_r.failFlag;
  assign crystalDriveEn = ((s_r.srcSel == SRC_PRI) ||
                           (s_r.srcSel == SRC_PRIPLL)) &&
                          ((s_r.primMode == PM_XT) ||
                           (s_r.primMode == PM_HS));
  assign secondaryOscEn = (s_r.srcSel == SRC_SEC);
  assign clockMode = modeIdx;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_capture_src;
    !s_r.captured && configProgrammed |=>
      s_r.srcSel == src_t'($past(initialSourceSelect)) && s_r.captured;
  endproperty
  a_capture_src: assert property (p_capture_src)
    else $error("source not taken from configuration");

  property p_erased_default;
    !s_r.captured && !configProgrammed |=> s_r.srcSel == SRC_FRCDIVN;
  endproperty
  a_erased_default: assert property (p_erased_default)
    else $error("erased configuration not on fast rc");

  property p_halve;
    foscTick |=> instrClk != $past(instrClk) && periphClk == instrClk;
  endproperty
  a_halve: assert property (p_halve)
    else $error("instruction clock did not toggle on tick");

  property p_no_glitch;
    $changed(instrClk) |-> $past(foscTick);
  endproperty
  a_no_glitch: assert property (p_no_glitch)
    else $error("instruction clock moved without a tick");

  property p_low_power_internal_rc_ref;
    ##1 watchdogRefClk == $past(lowPowerRcClk) &&
        monitorRefClk == watchdogRefClk;
  endproperty
  a_low_power_internal_rc_ref: assert property (p_low_power_internal_rc_ref)
    else $error("reference clock not the low-power rc");

  property p_post_map;
    postSel == 2'b00 |-> n2Factor == DIV_W'(2);
  endproperty
  a_post_map: assert property (p_post_map)
    else $error("postscale zero is not two");

  property p_fb_map;
    s_r.pllFbReg == 9'h01E |-> mFactor == DIV_W'(32) &&
      (preSel != 5'h00 || n1Factor == DIV_W'(2));
  endproperty
  a_fb_map: assert property (p_fb_map)
    else $error("feedback or prescale encoding wrong");

  property p_pll_path;
    isPllMode |-> foscTick == postIf.tickOut;
  endproperty
  a_pll_path: assert property (p_pll_path)
    else $error("pll mode not clocked from post divider");

  property p_ec_direct;
    s_r.primMode == PM_EC |-> !crystalDriveEn;
  endproperty
  a_ec_direct: assert property (p_ec_direct)
    else $error("crystal driven in external clock mode");

  property p_fail_set;
    s_r.captured && !s_r.failFlag && !foscTick && lprcEdge &&
      s_r.lprcNoTick == 2'h1 |=> clockFailed && s_r.srcSel == SRC_FRC;
  endproperty
  a_fail_set: assert property (p_fail_set)
    else $error("clock loss not flagged or no fallback");

  property p_rd_latency;
    regRead && regAddr == `CCS_ADDR_PLL_FEEDBACK_REG |=>
      regRdData == {7'h00, $past(s_r.pllFbReg)};
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("feedback register read back wrong");

  property p_mode_count;
    clockMode < 4'(`CCS_MODE_COUNT);
  endproperty
  a_mode_count: assert property (p_mode_count)
    else $error("mode number out of range");

  c_fail: cover property ($rose(clockFailed));
  c_pll: cover property (isPllMode && postIf.tickOut);
  c_rc_div: cover property (s_r.srcSel == SRC_FRCDIVN && rcIf.tickOut);
  c_write: cover property (regWrite && regAddr == `CCS_ADDR_CLOCK_DIVISOR_REG);

endmodule // clock_select_pll_ctl

// ==== design/clk_ctl_defs.svh ====
// offsets, field positions, reset values and counts of the clock control
`ifndef CLK_CTL_DEFS_SVH
`define CLK_CTL_DEFS_SVH

`define CCS_ADDR_W 4
`define CCS_DATA_W 16
`define CCS_ADDR_CLOCK_DIVISOR_REG 4'h0
`define CCS_ADDR_PLL_FEEDBACK_REG 4'h1
`define CCS_ADDR_STATUS 4'h2

`define CCS_CLOCK_DIVISOR_REG_RST 16'h0040
`define CCS_PLL_FEEDBACK_REG_RST 9'h030

`define CCS_RCDIV_LSB 8
`define CCS_POST_LSB 6
`define CCS_PRE_LSB 0
`define CCS_FAIL_BIT 3
`define CCS_MODE_LSB 4
`define CCS_PROG_BIT 8

`define CCS_MODE_COUNT 12
`define CCS_PRE_OFFSET 10'h002
`define CCS_FB_OFFSET 10'h002
`define CCS_FRC_DIV16 10'h010
`define CCS_FAIL_LOW_POWER_INTERNAL_RC_EDGES 2'h2

`endif

// ==== design/clk_ctl_pkg.sv ====
// types shared by the clock control modules
package clk_ctl_pkg;

  typedef enum logic [2:0] {
    SRC_FRC      = 3'b000,
    SRC_FRCPLL   = 3'b001,
    SRC_PRI      = 3'b010,
    SRC_PRIPLL   = 3'b011,
    SRC_SEC      = 3'b100,
    SRC_LOW_POWER_INTERNAL_RC     = 3'b101,
    SRC_FRCDIV16 = 3'b110,
    SRC_FRCDIVN  = 3'b111
  } src_t;

  typedef enum logic [1:0] {
    PM_EC  = 2'b00,
    PM_XT  = 2'b01,
    PM_HS  = 2'b10,
    PM_OFF = 2'b11
  } pmode_t;

endpackage // clk_ctl_pkg

// ==== design/div_if.sv ====
// tick in, divisor and tick out of one edge divider
interface div_if #(parameter int W = 10) ();
  logic tickIn;
  logic [W-1:0] divisor;
  logic tickOut;
  modport ctl (output tickIn, output divisor, input tickOut);
  modport div (input tickIn, input divisor, output tickOut);
endinterface // div_if

// ==== design/tick_divider.sv ====
// edge-count divider that takes a new divisor only at its wrap
module tick_divider #(
  parameter int W = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  div_if.div dv
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] active;
    logic tickOut;
  } div_state_t;

  div_state_t s_r;
  div_state_t s_nxt;

  initial begin
    if (W < 2) $error("tick_divider: W too small");
  end

  // ---------------------------------------------------------------
  // count input ticks, wrap at the active divisor
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.tickOut = 1'b0;
    if (dv.tickIn) begin
      if (s_r.cnt + W'(1) >= s_r.active) begin
        s_nxt.tickOut = 1'b1;
        s_nxt.cnt = '0;
        s_nxt.active = dv.divisor;
      end else begin
        s_nxt.cnt = s_r.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '{cnt: '0, active: W'(1), tickOut: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dv.tickOut = s_r.tickOut;

endmodule // tick_divider

// ==== tb/tb_clock_select_pll_ctl.sv ====
// self-checking bench for the clock select and pll control block
`include "clk_ctl_defs.svh"

module tb_clock_select_pll_ctl;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [`CCS_ADDR_W-1:0] regAddr = '0;
  logic [`CCS_DATA_W-1:0] regWrData = '0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [`CCS_DATA_W-1:0] regRdData;
  logic [2:0] srcSel = 3'h0;
  logic [1:0] primMode = 2'h0;
  logic cfgProg = 1'b0;
  logic oscLvl = 1'b0;
  logic lprcLvl = 1'b0;
  logic pllRefTick, pllFeedbackTick, pllEnable, instrClk, periphClk;
  logic watchdogRefClk, monitorRefClk, clockFailed;
  logic crystalDriveEn, secondaryOscEn;
  logic [3:0] clockMode;
  int err_total = 0;
  int cmp_count = 0;
  int edgeCnt = 0;
  int markI = 0, gapI = 0, markP = 0, gapP = 0;
  int markR = 0, gapR = 0, markF = 0, gapF = 0;
  logic prevI = 1'b0, prevP = 1'b0;

  // mode number is the index: {source, primary mode}
  localparam logic [4:0] MODE_CFG [12] = '{5'b111_01, 5'b110_01,
    5'b101_01, 5'b100_01, 5'b011_10, 5'b011_01, 5'b011_00, 5'b010_10,
    5'b010_01, 5'b010_00, 5'b001_01, 5'b000_01};
  // case 5: prescale 2, feedback 32, postscale 2
  // divider cases: config, clock divisor, feedback, expected gaps
  localparam logic [4:0] G_CFG [11] = '{5'b000_01, 5'b111_01, 5'b111_01,
    5'b111_01, 5'b110_01, 5'b001_01, 5'b001_01, 5'b011_01, 5'b011_10,
    5'b010_00, 5'b100_01};
  localparam logic [15:0] G_R0 [11] = '{16'h0040, 16'h0300, 16'h0040,
    16'h0700, 16'h0040, 16'h0000, 16'h0041, 16'h00DF, 16'h0080,
    16'h0040, 16'h0040};
  localparam logic [15:0] G_R1 [11] = '{16'h0030, 16'h0030, 16'h0030,
    16'h0030, 16'h0030, 16'h001E, 16'h0000, 16'h0005, 16'h0001,
    16'h0030, 16'h0030};
  localparam int G_I [11] = '{1, 16, 2, 256, 16, 2, 4, 8, 4, 1, 1};
  localparam int G_R [11] = '{0, 0, 0, 0, 0, 2, 3, 33, 2, 0, 0};
  localparam int G_F [11] = '{0, 0, 0, 0, 0, 32, 2, 7, 3, 0, 0};

  always #5 clk = ~clk;

  // ----------------------------------------
  // design
  // ----------------------------------------
  clock_select_pll_ctl u_clock_select_pll_ctl (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .initialSourceSelect(srcSel),
    .primaryOscMode(primMode), .configProgrammed(cfgProg),
    .fastRcClk(oscLvl), .primaryClk(oscLvl), .secondaryClk(oscLvl),
    .lowPowerRcClk(lprcLvl), .pllOscClk(oscLvl),
    .pllRefTick(pllRefTick), .pllFeedbackTick(pllFeedbackTick),
    .pllEnable(pllEnable), .instrClk(instrClk), .periphClk(periphClk),
    .watchdogRefClk(watchdogRefClk), .monitorRefClk(monitorRefClk),
    .clockFailed(clockFailed), .crystalDriveEn(crystalDriveEn),
    .secondaryOscEn(secondaryOscEn), .clockMode(clockMode)
  );

  // gaps between output events, counted in oscillator edges
  always @(posedge clk) begin
    prevI <= instrClk;
    prevP <= periphClk;
    if (instrClk !== prevI) begin
      gapI <= edgeCnt - markI;
      markI <= edgeCnt;
    end
    if (periphClk !== prevP) begin
      gapP <= edgeCnt - markP;
      markP <= edgeCnt;
    end
    if (pllRefTick === 1'b1) begin
      gapR <= edgeCnt - markR;
      markR <= edgeCnt;
    end
    if (pllFeedbackTick === 1'b1) begin
      gapF <= edgeCnt - markF;
      markF <= edgeCnt;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic configure(input logic [4:0] cfg, input logic prog);
    @(posedge clk);
    reset_n <= 1'b0;
    srcSel <= cfg[4:2];
    primMode <= cfg[1:0];
    cfgProg <= prog;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask

  // every oscillator level except the low-power rc, two cycles high and two low
  task automatic oscEdges(input int n);
    repeat (n) begin
      @(posedge clk);
      oscLvl <= 1'b1;
      edgeCnt <= edgeCnt + 1;
      repeat (2) @(posedge clk);
      oscLvl <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic lprcEdge();
    @(posedge clk);
    lprcLvl <= 1'b1;
    #1 check(watchdogRefClk, 1'b0, "wdt ref early");
    @(posedge clk);
    #1 check(watchdogRefClk, 1'b1, "wdt ref");
    check(monitorRefClk, 1'b1, "monitor ref");
    @(posedge clk);
    lprcLvl <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #200000;
    err_total++;
    summarize();
  end

  initial begin
    logic [15:0] d;
    logic [2:0] s;
    logic [1:0] p;
    int n;
    configure(5'b000_01, 1'b1);
    rd(`CCS_ADDR_CLOCK_DIVISOR_REG, d);
    check(d, `CCS_CLOCK_DIVISOR_REG_RST, "clock_divisor_reg reset");
    rd(`CCS_ADDR_PLL_FEEDBACK_REG, d);
    check(d, 16'(`CCS_PLL_FEEDBACK_REG_RST), "pll_feedback_reg reset");
    wr(`CCS_ADDR_PLL_FEEDBACK_REG, 16'hFFFF);
    rd(`CCS_ADDR_PLL_FEEDBACK_REG, d);
    check(d, 16'h01FF, "pll_feedback_reg width");
    wr(`CCS_ADDR_CLOCK_DIVISOR_REG, 16'h07DF);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, d);
    check(d, 16'h0000, "unmapped read");
    @(posedge clk);
    #1 check(regRdData, 16'h0000, "read data idle");
    rd(`CCS_ADDR_CLOCK_DIVISOR_REG, d);
    check(d, 16'h07DF, "clock_divisor_reg fields");
    $display("test registers done");

    configure(5'b000_00, 1'b0);
    rd(`CCS_ADDR_STATUS, d);
    check(d, 16'h0007, "unprogrammed status");
    check(clockMode, 16'h0000, "unprogrammed mode");
    for (int m = 0; m < `CCS_MODE_COUNT; m++) begin
      configure(MODE_CFG[m], 1'b1);
      s = MODE_CFG[m][4:2];
      p = MODE_CFG[m][1:0];
      rd(`CCS_ADDR_STATUS, d);
      check(d, {7'h00, 1'b1, 4'(m), 1'b0, s}, "status");
      check(clockMode, 16'(m), "mode");
      check(pllEnable, (s == 3'b001 || s == 3'b011), "pll en");
      check(crystalDriveEn, (s[2:1] == 2'b01 && (p == 2'b01 ||
            p == 2'b10)), "xtal");
      check(secondaryOscEn, (s == 3'b100), "sec en");
    end
    $display("test modes done");

    for (int i = 0; i < 11; i++) begin
      configure(G_CFG[i], 1'b1);
      wr(`CCS_ADDR_CLOCK_DIVISOR_REG, G_R0[i]);
      wr(`CCS_ADDR_PLL_FEEDBACK_REG, G_R1[i]);
      n = G_I[i];
      if (G_R[i] > n) n = G_R[i];
      if (G_F[i] > n) n = G_F[i];
      oscEdges(3 * n + 6);
      check(gapI[15:0], 16'(G_I[i]), "instr gap");
      check(gapP[15:0], 16'(G_I[i]), "periph gap");
      if (G_R[i] > 0) begin
        check(gapR[15:0], 16'(G_R[i]), "prescale gap");
        check(gapF[15:0], 16'(G_F[i]), "feedback gap");
      end
    end
    $display("test dividers done");

    configure(5'b111_01, 1'b1);
    lprcEdge();
    oscEdges(4);
    lprcEdge();
    oscEdges(4);
    check(clockFailed, 1'b0, "no fail with ticks");
    lprcEdge();
    lprcEdge();
    repeat (2) @(posedge clk);
    #1 check(clockFailed, 1'b1, "fail flag");
    rd(`CCS_ADDR_STATUS, d);
    check(d & 16'h000F, 16'h0008, "fail status");
    wr(`CCS_ADDR_STATUS, 16'h0008);
    rd(`CCS_ADDR_STATUS, d);
    check(d & 16'h0008, 16'h0000, "fail clear");
    check(clockFailed, 1'b0, "fail flag clear");
    $display("test fail monitor done");
    summarize();
  end

endmodule // tb_clock_select_pll_ctl
